// ---- core/fcc_pkg.sv ----
/*
 * Shared constants and carrier types for the flash command control and
 * status block: register offsets, field positions, command codes, reset
 * values and the packed structs that carry the register bus and the
 * flash command bus.
 * Assumes a 32-bit register bus with byte offsets and a single clock.
 */
package fcc_pkg;

	// Register bus geometry.
	localparam int FCC_ADDR_W = 12;
	localparam int FCC_DATA_W = 32;

	// Byte offsets of the registers that this port answers.
	localparam logic [FCC_ADDR_W-1:0] FCC_OFF_EVT_CLR = 12'h00c;
	localparam logic [FCC_ADDR_W-1:0] FCC_OFF_CTRL = 12'h014;
	localparam logic [FCC_ADDR_W-1:0] FCC_OFF_STATE = 12'h018;
	localparam logic [FCC_ADDR_W-1:0] FCC_OFF_ADDR = 12'h01c;
	localparam logic [FCC_ADDR_W-1:0] FCC_OFF_WORD_LOW = 12'h020;

	// Control register fields.
	localparam int FCC_CTRL_ABORT_BIT = 4;
	localparam int FCC_CTRL_CMD_LSB = 0;
	localparam int FCC_CMD_W = 3;

	// Status register fields.
	localparam int FCC_ST_LOCK_BIT = 5;
	localparam int FCC_ST_DONE_BIT = 4;
	localparam int FCC_ST_FAIL_BIT = 3;
	localparam int FCC_ST_OK_BIT = 2;
	localparam int FCC_ST_TAKEN_BIT = 1;
	localparam int FCC_ST_QUEUED_BIT = 0;

	// Event clear register fields.
	localparam int FCC_EC_OK_BIT = 1;
	localparam int FCC_EC_FAIL_BIT = 2;

	// Flash address width.
	localparam int FCC_FADDR_W = 22;

	// Command codes.
	localparam logic [2:0] FCC_CMD_NONE = 3'h0;
	localparam logic [2:0] FCC_CMD_READ = 3'h1;
	localparam logic [2:0] FCC_CMD_WRITE = 3'h2;
	localparam logic [2:0] FCC_CMD_ROW_WRITE = 3'h3;
	localparam logic [2:0] FCC_CMD_ERASE = 3'h4;
	localparam logic [2:0] FCC_CMD_FULL_ERASE = 3'h7;

	// Values after reset.
	localparam logic [31:0] FCC_RST_WORD = 32'h0000_0000;
	localparam logic [21:0] FCC_RST_FADDR = 22'h00_0000;

	// Index of each sticky event flag.
	localparam int FCC_FLAG_OK = 0;
	localparam int FCC_FLAG_FAIL = 1;
	localparam int FCC_FLAG_DONE = 2;
	localparam int FCC_NUM_FLAGS = 3;

	// Register bus request from the requester.
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [FCC_ADDR_W-1:0] addr;
		logic [FCC_DATA_W-1:0] wdata;
	} fcc_apb_req_t;

	// Command toward the flash command bus.
	typedef struct packed {
		logic valid;
		logic [FCC_CMD_W-1:0] cmd;
		logic [FCC_FADDR_W-1:0] addr;
		logic [FCC_DATA_W-1:0] wdata;
		logic abort;
	} fcc_fcb_req_t;

	// Answer from the flash command bus.
	typedef struct packed {
		logic accept;
		logic done;
		logic fail;
		logic [FCC_DATA_W-1:0] rdata;
	} fcc_fcb_rsp_t;

endpackage : fcc_pkg

// ---- core/fcc_evt_flag.sv ----
/*
 * One sticky event flag: a pulse sets it, a software clear pulse clears it.
 * Assumes both pulses are synchronous to i_clk; a set in the clear cycle wins.
 */
`timescale 1ns/1ps
module fcc_evt_flag import fcc_pkg::*; (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Event and clear pulses.
	input wire logic i_set,
	input wire logic i_clr,
	// Flag level.
	output logic o_flag
);

	// Held flag and its next value.
	logic flag_reg;
	logic flag_next;

	// The set is tested last so an event that lands on a clear is kept.
	always_comb begin
		flag_next = flag_reg;
		if (i_clr) begin
			flag_next = 1'b0;
		end
		if (i_set) begin
			flag_next = 1'b1;
		end
	end

	// Register the flag.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg;

endmodule : fcc_evt_flag

// ---- core/fcc_cmd_ctrl.sv ----
/*
 * Per-port command control and status logic of a flash controller.
 * Holds the control, status, event clear, address and low data word
 * registers of one register-bus port, queues commands toward the flash
 * command bus and tracks acceptance, completion and abort.
 * Assumes a single clock, an arbitration lock level from the other host
 * port, and a flash that answers accept, done and fail as one-cycle pulses.
 */
`timescale 1ns/1ps
// How it works
// R1: Control bit 4 requests abort of own command.
// R2: Abort acts only while command taken flag set.
// R3: Abort write ignores the command code field.
// R4: Abort bit reads back the abort request.
// R5: Valid code starts command with address, data.
// R6: Codes 1,2,3 are read, write, row write.
// R7: Software erases region before any write.
// R8: Codes 4 and 7 are sector, full erase.
// R9: Reserved codes 0, 5, 6 do nothing.
// R10: Acceptance clears code, sets command taken flag.
// R11: Code field reads the still pending command.
// R12: Each port owns its status register.
// R13: Lock bit shows host lock; holds commands.
// R14: Done bit set on finish, cleared by clears.
// R15: Fail bit follows fail event and clear.
// R16: Ok bit reads one when success event set.
// R17: Ok bit clears with success event clear.
// R18: Taken flag clears unless newer command taken.
// R19: Queued flag while waiting or abort requested.
// R20: Reserved bits read zero, writes ignored.
module fcc_cmd_ctrl import fcc_pkg::*; (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register bus.
	input wire fcc_apb_req_t i_apb,
	output logic [FCC_DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Flash command bus.
	output fcc_fcb_req_t o_fcb,
	input wire fcc_fcb_rsp_t i_fcb,
	// Arbitration lock held by the other host port.
	input wire logic i_host_lock
);

	// Pending command code and abort request.
	logic [FCC_CMD_W-1:0] cmd_reg;
	logic [FCC_CMD_W-1:0] cmd_next;
	logic abort_reg;
	logic abort_next;
	// Command taken flag and a command in flight on the flash bus.
	logic taken_reg;
	logic taken_next;
	logic busy_reg;
	logic busy_next;
	// Code of the command in flight, used to route read data.
	logic [FCC_CMD_W-1:0] flight_reg;
	logic [FCC_CMD_W-1:0] flight_next;
	// Sampled lock level.
	logic lock_reg;
	logic lock_next;
	// Address and low data word.
	logic [FCC_FADDR_W-1:0] addr_reg;
	logic [FCC_FADDR_W-1:0] addr_next;
	logic [FCC_DATA_W-1:0] word_reg;
	logic [FCC_DATA_W-1:0] word_next;
	// Flash bus request register.
	fcc_fcb_req_t fcb_reg;
	fcc_fcb_req_t fcb_next;
	// Bus answer registers.
	logic [FCC_DATA_W-1:0] prdata_reg;
	logic [FCC_DATA_W-1:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	// Sticky event flags: ok, fail, done.
	logic [FCC_NUM_FLAGS-1:0] flag_set;
	logic [FCC_NUM_FLAGS-1:0] flag_clr;
	logic [FCC_NUM_FLAGS-1:0] flag_q;

	// Decoded bus strobes.
	logic wr_en;
	logic wr_ctrl;
	logic wr_evt;
	logic clr_ok;
	logic clr_fail;
	logic accept_now;
	logic done_now;
	logic [FCC_DATA_W-1:0] state_word;

	// True for the five codes that start a flash command.
	function automatic logic cmd_valid(input logic [FCC_CMD_W-1:0] code);
		cmd_valid = (code == FCC_CMD_READ) || (code == FCC_CMD_WRITE) ||
			(code == FCC_CMD_ROW_WRITE) || (code == FCC_CMD_ERASE) ||
			(code == FCC_CMD_FULL_ERASE);
	endfunction : cmd_valid

	// Writes take effect in the access phase; pready is always high there.
	assign wr_en = i_apb.sel && i_apb.enable && i_apb.write;
	assign wr_ctrl = wr_en && (i_apb.addr == FCC_OFF_CTRL);
	assign wr_evt = wr_en && (i_apb.addr == FCC_OFF_EVT_CLR);
	assign clr_ok = wr_evt && i_apb.wdata[FCC_EC_OK_BIT];
	assign clr_fail = wr_evt && i_apb.wdata[FCC_EC_FAIL_BIT];
	// Only an answer to a request we really drive counts as acceptance.
	assign accept_now = fcb_reg.valid && i_fcb.accept;
	assign done_now = busy_reg && i_fcb.done;

	// Status word, private to this port; reserved bits stay zero.
	// R12: own status copy
	always_comb begin
		state_word = FCC_RST_WORD;
		// R13: lock bit
		state_word[FCC_ST_LOCK_BIT] = lock_reg;
		// R14: done bit
		state_word[FCC_ST_DONE_BIT] = flag_q[FCC_FLAG_DONE];
		// R15: fail bit
		state_word[FCC_ST_FAIL_BIT] = flag_q[FCC_FLAG_FAIL];
		// R16: ok bit
		state_word[FCC_ST_OK_BIT] = flag_q[FCC_FLAG_OK];
		state_word[FCC_ST_TAKEN_BIT] = taken_reg;
		// R19: queued bit
		state_word[FCC_ST_QUEUED_BIT] = (cmd_reg != FCC_CMD_NONE) || abort_reg;
	end

	// Sticky flags; the done flag falls with either event clear.
	always_comb begin
		flag_set[FCC_FLAG_OK] = done_now && !i_fcb.fail;
		flag_set[FCC_FLAG_FAIL] = done_now && i_fcb.fail;
		flag_set[FCC_FLAG_DONE] = done_now;
		// R17: ok clear
		flag_clr[FCC_FLAG_OK] = clr_ok;
		// R15: fail clear
		flag_clr[FCC_FLAG_FAIL] = clr_fail;
		// R14: done clear
		flag_clr[FCC_FLAG_DONE] = clr_ok || clr_fail;
	end

	// One flag cell per event.
	for (genvar g = 0; g < FCC_NUM_FLAGS; g++) begin : g_flag
		fcc_evt_flag u_flag (
			.i_clk(i_clk),
			.i_rst_n(i_rst_n),
			.i_set(flag_set[g]),
			.i_clr(flag_clr[g]),
			.o_flag(flag_q[g])
		);
	end

	// Command, abort and acceptance tracking.
	always_comb begin
		cmd_next = cmd_reg;
		abort_next = abort_reg;
		taken_next = taken_reg;
		busy_next = busy_reg;
		flight_next = flight_reg;
		lock_next = i_host_lock;
		// A finished command frees the flash and ends any abort.
		if (done_now) begin
			busy_next = 1'b0;
			abort_next = 1'b0;
		end
		if (wr_ctrl) begin
			if (i_apb.wdata[FCC_CTRL_ABORT_BIT]) begin
				// R1: abort request
				// R2: abort gated by taken
				// R3: code ignored
				if (taken_reg && busy_reg && !done_now) begin
					abort_next = 1'b1;
				end
			end else if (cmd_reg == FCC_CMD_NONE) begin
				// R5: start command
				// R6: read and writes
				// R8: erases
				// R9: reserved ignored
				if (cmd_valid(i_apb.wdata[FCC_CMD_W-1:0])) begin
					cmd_next = i_apb.wdata[FCC_CMD_W-1:0];
				end
			end
		end
		// Clearing either event drops the taken flag unless a newer command is in flight.
		if (clr_ok || clr_fail) begin
			// R18: taken clear
			taken_next = busy_next;
		end
		// R10: acceptance
		if (accept_now) begin
			cmd_next = FCC_CMD_NONE;
			taken_next = 1'b1;
			busy_next = 1'b1;
			flight_next = fcb_reg.cmd;
		end
	end

	// Flash bus request; the lock and a busy flash hold queued commands back.
	always_comb begin
		fcb_next.cmd = cmd_next;
		fcb_next.addr = addr_reg;
		fcb_next.wdata = word_reg;
		fcb_next.abort = abort_next;
		// R13: lock holds request
		fcb_next.valid = (cmd_next != FCC_CMD_NONE) && !i_host_lock && !busy_next;
	end

	// Address and data words; a read that completes without fail fills the low word.
	always_comb begin
		addr_next = addr_reg;
		word_next = word_reg;
		if (wr_en && (i_apb.addr == FCC_OFF_ADDR)) begin
			addr_next = i_apb.wdata[FCC_FADDR_W-1:0];
		end
		if (wr_en && (i_apb.addr == FCC_OFF_WORD_LOW)) begin
			word_next = i_apb.wdata;
		end
		if (done_now && !i_fcb.fail && (flight_reg == FCC_CMD_READ)) begin
			word_next = i_fcb.rdata;
		end
	end

	// Read answer, prepared in the setup phase so outputs come from flops.
	always_comb begin
		prdata_next = FCC_RST_WORD;
		pready_next = i_apb.sel && !i_apb.enable;
		pslverr_next = 1'b0;
		// R20: reserved bits zero
		if (i_apb.addr == FCC_OFF_CTRL) begin
			// R4: abort readback
			prdata_next[FCC_CTRL_ABORT_BIT] = abort_reg;
			// R11: pending code
			prdata_next[FCC_CMD_W-1:0] = cmd_reg;
		end else if (i_apb.addr == FCC_OFF_STATE) begin
			prdata_next = state_word;
		end else if (i_apb.addr == FCC_OFF_EVT_CLR) begin
			prdata_next[FCC_EC_OK_BIT] = flag_q[FCC_FLAG_OK];
			prdata_next[FCC_EC_FAIL_BIT] = flag_q[FCC_FLAG_FAIL];
		end else if (i_apb.addr == FCC_OFF_ADDR) begin
			prdata_next[FCC_FADDR_W-1:0] = addr_reg;
		end else if (i_apb.addr == FCC_OFF_WORD_LOW) begin
			prdata_next = word_reg;
		end else begin
			pslverr_next = pready_next;
		end
		if (!pready_next) begin
			prdata_next = FCC_RST_WORD;
		end
	end

	// Register every group.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cmd_reg <= FCC_CMD_NONE;
			abort_reg <= 1'b0;
			taken_reg <= 1'b0;
			busy_reg <= 1'b0;
			flight_reg <= FCC_CMD_NONE;
			lock_reg <= 1'b0;
			addr_reg <= FCC_RST_FADDR;
			word_reg <= FCC_RST_WORD;
			fcb_reg <= '0;
			prdata_reg <= FCC_RST_WORD;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			cmd_reg <= cmd_next;
			abort_reg <= abort_next;
			taken_reg <= taken_next;
			busy_reg <= busy_next;
			flight_reg <= flight_next;
			lock_reg <= lock_next;
			addr_reg <= addr_next;
			word_reg <= word_next;
			fcb_reg <= fcb_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign o_fcb = fcb_reg;
	assign o_prdata = prdata_reg;
	assign o_pready = pready_reg;
	assign o_pslverr = pslverr_reg;

	// An abort request only ever stands behind a taken command.
	a_abort_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
		abort_reg |-> taken_reg)
		else $error("abort held without a taken command");

	// An abort write must not load a command code.
	a_abort_no_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
		(wr_ctrl && i_apb.wdata[FCC_CTRL_ABORT_BIT] && !accept_now)
		|=> (cmd_reg == $past(cmd_reg)))
		else $error("abort write changed the command code");

	// A valid code into an empty slot is held as the pending command.
	a_cmd_load: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
		(wr_ctrl && !i_apb.wdata[FCC_CTRL_ABORT_BIT] && (cmd_reg == FCC_CMD_NONE) &&
		cmd_valid(i_apb.wdata[FCC_CMD_W-1:0]))
		|=> (cmd_reg == $past(i_apb.wdata[FCC_CMD_W-1:0])))
		else $error("valid command code not taken");

	// Reserved codes leave the slot empty.
	a_resv_ignore: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
		(wr_ctrl && (cmd_reg == FCC_CMD_NONE) && !cmd_valid(i_apb.wdata[FCC_CMD_W-1:0]))
		|=> (cmd_reg == FCC_CMD_NONE) && !fcb_reg.valid)
		else $error("reserved code queued a command");

	// Acceptance empties the slot and raises the taken flag.
	a_accept_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
		accept_now |=> (cmd_reg == FCC_CMD_NONE) && taken_reg && !fcb_reg.valid)
		else $error("acceptance did not clear code or set taken");

	// The lock holds the request low on the next edge.
	a_lock_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
		i_host_lock |=> !fcb_reg.valid ##0 lock_reg)
		else $error("request raised under host lock");

	// Completion shows as done and as exactly one of ok or fail.
	a_done_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
		done_now |=> flag_q[FCC_FLAG_DONE] && (flag_q[FCC_FLAG_OK] != flag_q[FCC_FLAG_FAIL]))
		else $error("completion not reported");

	// A fail clear with no new completion drops the fail and done bits.
	a_fail_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
		(clr_fail && !done_now) |=> !state_word[FCC_ST_FAIL_BIT] && !state_word[FCC_ST_DONE_BIT])
		else $error("fail clear ignored");

	// An ok clear with no new completion drops the ok bit.
	a_ok_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
		(clr_ok && !done_now) |=> !state_word[FCC_ST_OK_BIT])
		else $error("ok clear ignored");

	// The taken flag survives a clear while a newer command is in flight.
	a_taken_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
		((clr_ok || clr_fail) && busy_reg && !done_now) |=> taken_reg)
		else $error("taken flag lost with command in flight");

	// Acceptance without abort leaves nothing queued.
	a_queued_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R19
		(accept_now && !abort_next) |=> !state_word[FCC_ST_QUEUED_BIT])
		else $error("queued bit stuck after acceptance");

endmodule : fcc_cmd_ctrl

// ---- testbench/fcc_flash_model.sv ----
/*
 * Behavioural flash on the command bus: takes a request one cycle after
 * it rises, finishes after a set latency, and ends early on abort.
 * Assumes the bench sets latency and failure before each command.
 */
`timescale 1ns/1ps
module fcc_flash_model import fcc_pkg::*; (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Command side and knobs.
	input wire fcc_fcb_req_t i_req,
	input wire logic [7:0] i_lat,
	input wire logic i_fail,
	// Answer side.
	output fcc_fcb_rsp_t o_rsp
);
	logic busy_reg; // A command is in flight.
	logic [7:0] cnt_reg; // Cycles spent on it.
	logic [4:0] ab_reg; // Cycles the abort has stood.
	// Clocked answer; pulses last one cycle.
	always @(posedge i_clk) begin
		o_rsp.accept <= 1'b0;
		o_rsp.done <= 1'b0;
		o_rsp.fail <= 1'b0;
		// Idle data toggles, so a stale word never matches by luck.
		o_rsp.rdata <= ~o_rsp.rdata;
		if (!i_rst_n) begin
			busy_reg <= 1'b0;
			// Reset gives the idle data a known start, from this one driver only.
			o_rsp.rdata <= 32'h0;
		end else if (!busy_reg) begin
			if (i_req.valid) begin
				o_rsp.accept <= 1'b1;
				busy_reg <= 1'b1;
				cnt_reg <= 8'h00;
				ab_reg <= 5'h00;
			end
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			ab_reg <= i_req.abort ? ab_reg + 5'h01 : 5'h00;
			// An abort ends the command, reported as a failure.
			if (cnt_reg >= i_lat || ab_reg == 5'h10) begin
				o_rsp.done <= 1'b1;
				o_rsp.fail <= i_fail | i_req.abort;
				o_rsp.rdata <= {10'h000, i_req.addr} ^ 32'h0f0f_0000;
				busy_reg <= 1'b0;
			end
		end
	end
endmodule : fcc_flash_model

// ---- testbench/fcc_cmd_ctrl_tb.sv ----
/*
 * Self-checking bench of the command control block over its register bus.
 * Assumes a flash model on the command bus and no wait states.
 */
`timescale 1ns/1ps
module fcc_cmd_ctrl_tb import fcc_pkg::*;;
	logic i_clk = 1'b0; // System clock.
	logic i_rst_n = 1'b0; // Reset, low active.
	fcc_apb_req_t apb = '0; // Bus request.
	logic [31:0] prdata; // Read data.
	logic pready; // Ready.
	logic pslverr; // Error.
	fcc_fcb_req_t fcb_req; // Toward flash.
	fcc_fcb_rsp_t fcb_rsp; // From flash.
	fcc_fcb_req_t got_req; // Last accepted command.
	logic lock = 1'b0; // Host lock.
	logic [7:0] lat = 8'h0c; // Flash latency.
	logic fl = 1'b0; // Flash fails next.
	int n_acc = 0; // Accepted commands.
	int err_total = 0; // Mismatches.
	int num_checks = 0; // Comparisons.
	logic [31:0] q; // Scratch read word.
	logic [31:0] v[4] = '{32'h0, 32'h5, 32'h6, 32'hffff_ffe8}; // Words that queue nothing.
	always #10 i_clk = ~i_clk;
	fcc_cmd_ctrl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(apb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_fcb(fcb_req), .i_fcb(fcb_rsp),
		.i_host_lock(lock));
	fcc_flash_model u_flash (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(fcb_req),
		.i_lat(lat), .i_fail(fl), .o_rsp(fcb_rsp));
	// Record what the flash took.
	always @(posedge i_clk) begin
		if (fcb_req.valid && fcb_rsp.accept) begin
			got_req <= fcb_req;
			n_acc <= n_acc + 1;
		end
	end
	// Compare one value.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One bus transfer; the error flag must mark unmapped places only.
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic bad;
		bad = !(a inside {FCC_OFF_EVT_CLR, FCC_OFF_CTRL, FCC_OFF_STATE, FCC_OFF_ADDR,
			FCC_OFF_WORD_LOW});
		@(posedge i_clk);
		apb <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
		@(posedge i_clk);
		apb.enable <= 1'b1;
		// Ready and the answer are taken at the edge that ends the access phase.
		@(posedge i_clk);
		r = prdata;
		check(32'(pready), 32'h1);
		check(32'(pslverr), 32'(bad));
		apb <= '0;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rd
	// Poll the done bit under a bounded count.
	task automatic wait_done;
		int i;
		q = 32'h0;
		for (i = 0; i < 120 && !q[FCC_ST_DONE_BIT]; i++) xfer(1'b0, FCC_OFF_STATE, 32'h0, q);
		check(32'(q[FCC_ST_DONE_BIT]), 32'h1);
	endtask : wait_done
	// Write a code and follow it through queue and acceptance.
	task automatic issue(input logic [2:0] c);
		wr(FCC_OFF_CTRL, 32'(c));
		rd(FCC_OFF_STATE, 32'h01);
		rd(FCC_OFF_CTRL, 32'h0);
		rd(FCC_OFF_STATE, 32'h02);
		check(32'(got_req.cmd), 32'(c));
	endtask : issue
	task automatic run_cmd(input logic [2:0] c, input logic [21:0] fa, input logic [31:0] fd,
		input logic f);
		fl <= f;
		wr(FCC_OFF_ADDR, 32'(fa));
		wr(FCC_OFF_WORD_LOW, fd);
		issue(c);
		check(32'(got_req.addr), 32'(fa));
		check(got_req.wdata, fd);
		wait_done();
		rd(FCC_OFF_STATE, f ? 32'h1a : 32'h16);
		rd(FCC_OFF_EVT_CLR, f ? 32'h4 : 32'h2);
		if (c == FCC_CMD_READ && !f) rd(FCC_OFF_WORD_LOW, {10'h0, fa} ^ 32'h0f0f_0000);
		wr(FCC_OFF_EVT_CLR, f ? 32'h4 : 32'h2);
		rd(FCC_OFF_STATE, 32'h0);
	endtask : run_cmd
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// Cut a hang short well past the expected run.
	initial begin
		repeat (20000) @(posedge i_clk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(FCC_OFF_STATE, 32'h0);
		wr(FCC_OFF_STATE, 32'hffff_ffff);
		rd(FCC_OFF_STATE, 32'h0);
		xfer(1'b0, 12'h040, 32'h0, q);
		// Reserved codes and bits queue nothing.
		foreach (v[i]) begin
			wr(FCC_OFF_CTRL, v[i]);
			rd(FCC_OFF_CTRL, 32'h0);
			rd(FCC_OFF_STATE, 32'h0);
		end
		check(32'(n_acc), 32'h0);
		$display("test reserved done");
		run_cmd(FCC_CMD_ERASE, 22'h00_0400, 32'h0, 1'b0);
		run_cmd(FCC_CMD_FULL_ERASE, 22'h00_0000, 32'h0, 1'b0);
		run_cmd(FCC_CMD_WRITE, 22'h3f_fffc, 32'ha5c3_0f96, 1'b0);
		run_cmd(FCC_CMD_ROW_WRITE, 22'h00_0800, 32'h1234_5678, 1'b0);
		run_cmd(FCC_CMD_READ, 22'h2a_aaa0, 32'h0, 1'b0);
		run_cmd(FCC_CMD_ERASE, 22'h01_0000, 32'h0, 1'b1);
		$display("test commands done");
		// The failing erase left the flash set to fail; the held read must succeed.
		fl <= 1'b0;
		lock <= 1'b1;
		wr(FCC_OFF_CTRL, 32'(FCC_CMD_READ));
		rd(FCC_OFF_CTRL, 32'h1);
		rd(FCC_OFF_STATE, 32'h21);
		check(32'(fcb_req.valid), 32'h0);
		lock <= 1'b0;
		wait_done();
		wr(FCC_OFF_EVT_CLR, 32'h2);
		$display("test lock done");
		lat <= 8'hc8;
		issue(FCC_CMD_ERASE);
		wr(FCC_OFF_CTRL, 32'h13);
		rd(FCC_OFF_CTRL, 32'h10);
		check(32'(fcb_req.abort), 32'h1);
		rd(FCC_OFF_STATE, 32'h03);
		wait_done();
		rd(FCC_OFF_STATE, 32'h1a);
		check(32'(n_acc), 32'h8);
		wr(FCC_OFF_EVT_CLR, 32'h4);
		rd(FCC_OFF_STATE, 32'h0);
		wr(FCC_OFF_CTRL, 32'h12);
		rd(FCC_OFF_STATE, 32'h0);
		check(32'(fcb_req.abort), 32'h0);
		$display("test abort done");
		lat <= 8'h20;
		wr(FCC_OFF_CTRL, 32'(FCC_CMD_READ));
		wait_done();
		// A new command lands while ok, done and taken still stand from the read.
		wr(FCC_OFF_CTRL, 32'(FCC_CMD_ERASE));
		rd(FCC_OFF_STATE, 32'h17);
		rd(FCC_OFF_CTRL, 32'h0);
		rd(FCC_OFF_STATE, 32'h16);
		wr(FCC_OFF_EVT_CLR, 32'h2);
		rd(FCC_OFF_STATE, 32'h02);
		wait_done();
		wr(FCC_OFF_EVT_CLR, 32'h2);
		rd(FCC_OFF_STATE, 32'h0);
		$display("test taken done");
		tally_and_finish();
	end
endmodule : fcc_cmd_ctrl_tb
